// >>> core/lftc_codec.sv
// Purpose: downlink decoder, mode control, uplink encoder, tx FIFO
// Assumes: carrier_i keeps running through reader gaps
// Notes: demod_i high while the carrier is removed
`timescale 1ns/100ps
module lftc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic full_r, full_nxt, empty_r, empty_nxt, push, pop;
  // Pointer and fill level update
  always_comb begin
    push = in_valid_i & ~full_r;
    pop = out_ready_i & ~empty_r;
    wp_nxt = wp_r + {{(AW-1){1'b0}}, push};
    rp_nxt = rp_r + {{(AW-1){1'b0}}, pop};
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    full_nxt = cnt_nxt == (AW+1)'(D);
    empty_nxt = cnt_nxt == '0;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else if (ce_i) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
      empty_r <= empty_nxt;
    end
  end
  // Storage array
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
  assign in_ready_o = ~full_r;
  assign out_valid_o = ~empty_r;
  assign out_data_o = mem_r[rp_r];
endmodule : lftc_fifo

module lftc_codec
  import lftc_pkg::*;
#(
  parameter int FOFF_CYC_P = lftc_pkg::FOFF_CYC,
  parameter int FIFO_D = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Air front end
  input wire logic carrier_i,
  input wire logic demod_i,
  input wire logic field_i,
  output logic mod_o,
  // Configuration
  input wire logic [2:0] cfg_i,
  input wire logic inv_i,
  // Uplink data
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic tx_busy_o,
  // Downlink results
  output lftc_pkg::lftc_evt_type rx_evt_o,
  output logic [7:0] rx_data_o,
  output lftc_pkg::lftc_mode_type mode_o
);
  import lftc_pkg::*;
  localparam int FW = $clog2(FOFF_CYC_P + 1);
  localparam logic [FW-1:0] FOFF_END = FW'(FOFF_CYC_P);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  function automatic lftc_sym_type classify(input logic [7:0] v);
    if (v >= ZERO_MIN && v <= ZERO_MAX) classify = S_ZERO;
    else if (v >= ONE_MIN && v <= ONE_MAX) classify = S_ONE;
    else if (v >= CV_MIN && v <= CV_MAX) classify = S_CV;
    else classify = S_ERR;
  endfunction : classify

  // Pin synchronisers: bit 0 carrier, 1 gap, 2 field
  logic [2:0] s1_r, s2_r, s3_r;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ce_i) begin
      s1_r <= {field_i, demod_i, carrier_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic tc_tick, half_tick, pe, fld, stop_ev, reply_ev;
  assign tc_tick = s2_r[0] & ~s3_r[0];
  assign half_tick = s2_r[0] ^ s3_r[0];
  assign pe = s2_r[1] & ~s3_r[1];
  assign fld = s2_r[2];

  // Falling-edge spacing counter in Tc
  logic [7:0] ivl_r, ivl_nxt;
  always_comb begin
    ivl_nxt = ivl_r;
    if (pe) ivl_nxt = '0;
    else if (tc_tick && ivl_r != IVL_RST) ivl_nxt = ivl_r + 8'h01;
  end
  assign stop_ev = tc_tick && !pe && (ivl_r + 8'h01) == STOP_TC;
  assign reply_ev = tc_tick && !pe && (ivl_r + 8'h01) == REPLY_TC;

  // Downlink frame decoder
  lftc_rx_type rx_st_r, rx_nxt;
  lftc_evt_type evt_r, evt_nxt;
  lftc_sym_type sym;
  lftc_mode_type mode_r, mode_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic [2:0] bcnt_r, bcnt_nxt, swc_r, swc_nxt;
  logic [4:0] sw_r, sw_nxt;
  logic bitv, sw_hit, sof_hit;
  always_comb begin
    rx_nxt = rx_st_r;
    byte_nxt = byte_r;
    bcnt_nxt = bcnt_r;
    sw_nxt = sw_r;
    swc_nxt = swc_r;
    evt_nxt = '0;
    sw_hit = 1'b0;
    sof_hit = 1'b0;
    sym = classify(ivl_r);
    bitv = sym == S_ONE;
    if (pe) begin
      case (rx_st_r)
        RX_IDLE: begin
          rx_nxt = RX_LEAD;
          swc_nxt = '0;
          bcnt_nxt = '0;
        end
        RX_LEAD, RX_SOF0, RX_BARE: begin
          if (rx_st_r == RX_SOF0 && sym == S_CV) begin
            rx_nxt = RX_FRAME;
            evt_nxt.sof = 1'b1;
            sof_hit = 1'b1;
          end else if (sym == S_ZERO || sym == S_ONE) begin
            sw_nxt = {bitv, sw_r[4:1]};
            swc_nxt = swc_r + 3'h1;
            rx_nxt = (rx_st_r == RX_LEAD && !bitv) ? RX_SOF0 : RX_BARE;
            if (swc_r == 3'h4 && sw_nxt == SW_PAT) sw_hit = 1'b1;
          end else begin
            rx_nxt = RX_DROP;
          end
        end
        RX_FRAME: begin
          if (sym == S_ZERO || sym == S_ONE) begin
            byte_nxt = {bitv, byte_r[7:1]};
            bcnt_nxt = bcnt_r + 3'h1;
            evt_nxt.byte_v = bcnt_r == 3'h7;
          end else begin
            rx_nxt = RX_DROP;
            evt_nxt.err = 1'b1;
          end
        end
        default: rx_nxt = rx_st_r;
      endcase
    end else if (stop_ev) begin
      evt_nxt.slot = rx_st_r == RX_LEAD && mode_r == M_XCHG;
      evt_nxt.eof = rx_st_r == RX_FRAME;
      rx_nxt = RX_IDLE;
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ivl_r <= IVL_RST;
      rx_st_r <= RX_IDLE;
      evt_r <= '0;
      byte_r <= '0;
      bcnt_r <= '0;
      sw_r <= '0;
      swc_r <= '0;
    end else if (ce_i) begin
      ivl_r <= ivl_nxt;
      rx_st_r <= rx_nxt;
      evt_r <= evt_nxt;
      byte_r <= byte_nxt;
      bcnt_r <= bcnt_nxt;
      sw_r <= sw_nxt;
      swc_r <= swc_nxt;
    end
  end

  // Mode control, field-off timer and listening window
  logic [FW-1:0] foff_r, foff_nxt;
  logic [9:0] wc_r, wc_nxt;
  logic pend_r, pend_nxt, go_x, fifo_v, fifo_rd;
  logic [7:0] fifo_d;
  lftc_tx_type tx_st_r, tx_nxt;
  always_comb begin
    mode_nxt = mode_r;
    wc_nxt = wc_r;
    foff_nxt = foff_r;
    if (fld) foff_nxt = '0;
    else if (foff_r != FOFF_END) foff_nxt = foff_r + 1'b1;
    if (!fld && foff_r == FOFF_END) begin
      mode_nxt = M_OFF;
    end else begin
      case (mode_r)
        M_OFF: begin
          if (fld) mode_nxt = M_SETTLE;
          wc_nxt = '0;
        end
        M_SETTLE: begin
          if (half_tick) wc_nxt = wc_r + 10'h001;
          if (half_tick && wc_nxt == SETTLE_HT) begin
            mode_nxt = M_WIN;
            wc_nxt = '0;
          end
        end
        M_WIN: begin
          if (half_tick) wc_nxt = wc_r + 10'h001;
          if (sw_hit || sof_hit) mode_nxt = M_XCHG;
          else if (half_tick && wc_nxt == WIN_HT) mode_nxt = M_BCAST;
        end
        default: mode_nxt = mode_r;
      endcase
    end
    // Reply request: set by a request end, set wins over clear
    go_x = pend_r && reply_ev && mode_r == M_XCHG && tx_st_r == TX_IDLE;
    pend_nxt = (pend_r && !go_x) ||
      (mode_r == M_XCHG && (evt_nxt.eof || evt_nxt.slot));
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= M_OFF;
      wc_r <= '0;
      foff_r <= '0;
      pend_r <= 1'b0;
    end else if (ce_i) begin
      mode_r <= mode_nxt;
      wc_r <= wc_nxt;
      foff_r <= foff_nxt;
      pend_r <= pend_nxt;
    end
  end

  // Uplink data buffer
  lftc_fifo #(.W(8), .D(FIFO_D)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(fifo_v),
    .out_ready_i(fifo_rd),
    .out_data_o(fifo_d)
  );

  // Uplink encoder: Manchester or bi-phase, SOF in exchange mode
  logic [7:0] sh_r, sh_nxt;
  logic [5:0] tmr_r, tmr_nxt, half_r, half_nxt, bc_half;
  logic [2:0] bc_r, bc_nxt;
  logic hb_r, hb_nxt, mod_r, mod_nxt, bph_r, bph_nxt, busy_r, last;
  always_comb begin
    tx_nxt = tx_st_r;
    sh_nxt = sh_r;
    tmr_nxt = tmr_r;
    half_nxt = half_r;
    bc_nxt = bc_r;
    hb_nxt = hb_r;
    mod_nxt = mod_r;
    bph_nxt = bph_r;
    fifo_rd = 1'b0;
    last = 1'b0;
    case (cfg_i[1:0])
      2'b00: bc_half = HALF_2K;
      2'b01: bc_half = HALF_4K;
      default: bc_half = HALF_8K;
    endcase
    case (tx_st_r)
      TX_IDLE: begin
        tmr_nxt = '0;
        hb_nxt = 1'b0;
        bc_nxt = '0;
        mod_nxt = 1'b0;
        if (go_x && fifo_v) begin
          tx_nxt = TX_SOF;
          sh_nxt = SOF_BITS;
          bph_nxt = 1'b0;
          half_nxt = inv_i ? HALF_2K : HALF_4K;
          mod_nxt = SOF_BITS[0];
        end else if (mode_r == M_BCAST && fifo_v) begin
          tx_nxt = TX_DATA;
          fifo_rd = 1'b1;
          sh_nxt = fifo_d;
          bph_nxt = cfg_i[2];
          half_nxt = bc_half;
          mod_nxt = cfg_i[2] ? 1'b1 : fifo_d[0];
        end
      end
      default: begin
        if (tc_tick) tmr_nxt = tmr_r + 6'h01;
        if (tc_tick && tmr_nxt == half_r) begin
          tmr_nxt = '0;
          hb_nxt = ~hb_r;
          if (!hb_r) begin
            // Mid-bit: Manchester always, bi-phase only for zero
            mod_nxt = (bph_r && sh_r[0]) ? mod_r : ~mod_r;
          end else begin
            bc_nxt = bc_r + 3'h1;
            sh_nxt = {1'b0, sh_r[7:1]};
            last = tx_st_r == TX_SOF ? bc_r == SOF_LAST : bc_r == 3'h7;
            if (last) begin
              bc_nxt = '0;
              if (fifo_v) begin
                fifo_rd = 1'b1;
                sh_nxt = fifo_d;
                tx_nxt = TX_DATA;
              end else begin
                tx_nxt = TX_IDLE;
              end
            end
            // Bit start: bi-phase toggles, Manchester sets level
            mod_nxt = bph_r ? ~mod_r : sh_nxt[0];
            if (tx_nxt == TX_IDLE) mod_nxt = 1'b0;
          end
        end
      end
    endcase
    if (mode_r == M_OFF) begin
      tx_nxt = TX_IDLE;
      mod_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_r <= TX_IDLE;
      sh_r <= '0;
      tmr_r <= '0;
      half_r <= HALF_4K;
      bc_r <= '0;
      hb_r <= 1'b0;
      mod_r <= 1'b0;
      bph_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (ce_i) begin
      tx_st_r <= tx_nxt;
      sh_r <= sh_nxt;
      tmr_r <= tmr_nxt;
      half_r <= half_nxt;
      bc_r <= bc_nxt;
      hb_r <= hb_nxt;
      mod_r <= mod_nxt;
      bph_r <= bph_nxt;
      busy_r <= tx_nxt != TX_IDLE;
    end
  end
  assign mod_o = mod_r;
  assign tx_busy_o = busy_r;
  assign rx_evt_o = evt_r;
  assign rx_data_o = byte_r;
  assign mode_o = mode_r;

  // Checks
  off_mode_a: assert property (
    (ce_i && !fld && foff_r == FOFF_END) |=> mode_r == M_OFF)
    else $error("field off did not reset mode");
  xchg_src_a: assert property (
    $rose(mode_r == M_XCHG) |-> $past(mode_r) == M_WIN)
    else $error("exchange entered outside window");
  reply_req_a: assert property (
    $rose(tx_st_r == TX_SOF) |->
      $past(pend_r) && ($past(ivl_r) + 8'h01) == REPLY_TC)
    else $error("reply without request or wrong gap");
  sof_first_a: assert property (
    ($rose(tx_st_r == TX_DATA) && mode_r == M_XCHG) |->
      $past(tx_st_r) == TX_SOF)
    else $error("exchange reply without SOF");
  bcast_nosof_a: assert property (
    mode_r == M_BCAST |-> tx_st_r != TX_SOF)
    else $error("SOF in broadcast mode");
  xchg_rate_a: assert property (
    (tx_st_r != TX_IDLE && mode_r == M_XCHG) |->
      !bph_r && (half_r == HALF_4K || half_r == HALF_2K))
    else $error("exchange reply coding wrong");
  stop_idle_a: assert property (
    (ce_i && stop_ev) |=> rx_st_r == RX_IDLE)
    else $error("stop condition not taken");
  err_src_a: assert property (
    evt_r.err |-> $past(rx_st_r) == RX_FRAME && mode_r != M_OFF)
    else $error("framing error outside frame");
  cover property ($rose(mode_r == M_XCHG));
  cover property (evt_r.slot);
  cover property ($rose(tx_st_r == TX_DATA) && mode_r == M_BCAST);
endmodule : lftc_codec

// >>> core/lftc_pkg.sv
// Purpose: constants and types of the tag air-interface codec
// Assumes: times counted in carrier periods (Tc) of the field, except the field-off time, counted in system clock cycles
package lftc_pkg;
  localparam int CLK_MHZ = 40;
  localparam int FOFF_US = 5000;
  localparam int FOFF_CYC = FOFF_US * CLK_MHZ;
  localparam int READY_US = 1200;
  localparam int PWRUP_READY_US = 2330;
  // Half carrier periods: 312.5 and 232.5 Tc
  localparam logic [9:0] SETTLE_HT = 10'h0271;
  localparam logic [9:0] WIN_HT = 10'h01d1;
  localparam logic [7:0] ZERO_MIN = 8'h12;
  localparam logic [7:0] ZERO_MAX = 8'h16;
  localparam logic [7:0] ONE_MIN = 8'h1a;
  localparam logic [7:0] ONE_MAX = 8'h1e;
  localparam logic [7:0] CV_MIN = 8'h22;
  localparam logic [7:0] CV_MAX = 8'h26;
  localparam logic [7:0] STOP_TC = 8'h2a;
  // Typical reply wait 209 Tc, inside 204..213
  localparam logic [7:0] REPLY_TC = 8'hd1;
  localparam logic [7:0] IVL_RST = 8'hff;
  // Half-bit lengths in Tc for 2, 4 and 8 kbit/s
  localparam logic [5:0] HALF_2K = 6'h20;
  localparam logic [5:0] HALF_4K = 6'h10;
  localparam logic [5:0] HALF_8K = 6'h08;
  localparam logic [7:0] SOF_BITS = 8'h03;
  localparam logic [2:0] SOF_LAST = 3'h2;
  localparam logic [4:0] SW_PAT = 5'h18;
  typedef enum logic [2:0] {
    M_OFF = 3'b000, M_SETTLE = 3'b001, M_WIN = 3'b010,
    M_BCAST = 3'b011, M_XCHG = 3'b100
  } lftc_mode_type;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_LEAD = 3'b001, RX_SOF0 = 3'b010,
    RX_BARE = 3'b011, RX_FRAME = 3'b100, RX_DROP = 3'b101
  } lftc_rx_type;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_SOF = 2'b01, TX_DATA = 2'b10
  } lftc_tx_type;
  typedef enum logic [1:0] {
    S_ZERO = 2'b00, S_ONE = 2'b01, S_CV = 2'b10, S_ERR = 2'b11
  } lftc_sym_type;
  typedef struct packed {
    logic sof;
    logic eof;
    logic slot;
    logic err;
    logic byte_v;
  } lftc_evt_type;
endpackage : lftc_pkg

// >>> bench/lftc_reader.sv
// Purpose: reader model for the tag codec bench
// Assumes: carrier period 200 ns, times in carrier periods
// Notes: carrier runs only while the field is on
`timescale 1ns/100ps
module lftc_reader (
  // Air side
  output logic carrier_o,
  output logic demod_o,
  output logic field_o
);
  // Carrier toggles at a phase unrelated to the system clock
  initial begin
    carrier_o = 1'b0;
    demod_o = 1'b0;
    field_o = 1'b0;
    #7.3;
    forever begin
      #100;
      carrier_o = field_o & ~carrier_o;
    end
  end
  // Field on or off; the bench keeps off times long enough
  task automatic field_set(input logic on);
    field_o = on;
  endtask : field_set
  // Wait a number of carrier periods
  task automatic tc(input int n);
    repeat (n) @(posedge carrier_o);
  endtask : tc
  // Gap of 6 periods, starting s periods after the previous one
  task automatic gap(input int s);
    tc(s - 6);
    demod_o = 1'b1;
    tc(6);
    demod_o = 1'b0;
  endtask : gap
  // Data byte, one spacing per bit
  task automatic byte_out(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      gap(d[i] ? 28 : 20);
    end
  endtask : byte_out
  // Frame start: lead pulse, zero, violation
  task automatic sof();
    gap(6);
    gap(20);
    gap(36);
  endtask : sof
  // Bare switch pattern 00011 after a lead pulse
  task automatic swp();
    gap(6);
    for (int i = 0; i < 5; i++) begin
      gap(i < 3 ? 20 : 28);
    end
  endtask : swp
endmodule : lftc_reader

// >>> bench/tb.sv
// Purpose: self-checking bench for the tag air-interface codec
// Assumes: carrier 200 ns, field-off limit scaled to 200 cycles
// Notes: expected levels come from a queue model of the encoders
`timescale 1ns/100ps
module tb;
  import lftc_pkg::*;
  localparam int LIMIT = 80000;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic carrier;
  logic demod;
  logic field;
  logic [2:0] cfg_i = 3'h4;
  logic inv_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic mod_o;
  logic tx_ready_o;
  logic tx_busy_o;
  lftc_evt_type rx_evt_o;
  lftc_evt_type evs = '0;
  logic [7:0] rx_data_o;
  lftc_mode_type mode_o;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 32'h94db;
  int cyc = 0;
  int n;
  logic lv;
  logic [7:0] q[$];
  logic [7:0] gq[$];
  logic hq[$];
  logic [2:0] cfgs[4] = '{3'h5, 3'h0, 3'h6, 3'h3};

  always #12.5 clk_sys_i = ~clk_sys_i;

  lftc_reader i_lftc_reader (
    .carrier_o(carrier),
    .demod_o(demod),
    .field_o(field)
  );
  lftc_codec #(.FOFF_CYC_P(200), .FIFO_D(8)) i_lftc_codec (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .carrier_i(carrier),
    .demod_i(demod),
    .field_i(field),
    .mod_o(mod_o),
    .cfg_i(cfg_i),
    .inv_i(inv_i),
    .tx_valid_i(tx_valid_i),
    .tx_data_i(tx_data_i),
    .tx_ready_o(tx_ready_o),
    .tx_busy_o(tx_busy_o),
    .rx_evt_o(rx_evt_o),
    .rx_data_o(rx_data_o),
    .mode_o(mode_o)
  );

  // Collect downlink events and bytes; cut a hang short
  always @(posedge clk_sys_i) begin
    evs <= lftc_evt_type'(evs | rx_evt_o);
    if (rx_evt_o.byte_v === 1'b1) begin
      gq.push_back(rx_data_o);
    end
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc_n(input int m);
    repeat (m) @(negedge clk_sys_i);
  endtask : cyc_n

  task automatic wait_mode(input lftc_mode_type m, input int lim);
    n = 0;
    while (mode_o !== m && n < lim) begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask : wait_mode

  // Model: half-bit levels of Manchester or differential bi-phase
  task automatic enc(input logic b, input logic bp);
    if (bp) begin
      lv = ~lv;
      hq.push_back(lv);
      if (!b) begin
        lv = ~lv;
      end
      hq.push_back(lv);
    end else begin
      hq.push_back(b);
      hq.push_back(~b);
    end
  endtask : enc

  // Offer bytes to the FIFO, keeping those it takes
  task automatic fill(input int m);
    logic tk;
    @(negedge clk_sys_i);
    for (int i = 0; i < m; i++) begin
      tx_data_i = 8'($random(seed));
      tx_valid_i = 1'b1;
      tk = tx_ready_o;
      @(negedge clk_sys_i);
      if (tk === 1'b1) begin
        q.push_back(tx_data_i);
      end
    end
    tx_valid_i = 1'b0;
  endtask : fill

  // Wait for the uplink to start, then compare every half bit
  task automatic cap(input int h);
    n = 0;
    while (tx_busy_o !== 1'b1 && n < 3000) begin
      @(negedge clk_sys_i);
      n++;
    end
    cyc_n(h / 2);
    while (hq.size() > 0) begin
      chk(mod_o, hq.pop_front());
      cyc_n(h);
    end
    cyc_n(h);
    chk({tx_busy_o, mod_o}, 2'h0);
  endtask : cap

  // Request frame with one byte, then check the reply
  task automatic reply(input int h);
    logic [7:0] b;
    lv = 1'b0;
    enc(1'b1, 1'b0);
    enc(1'b1, 1'b0);
    enc(1'b0, 1'b0);
    foreach (q[i]) begin
      for (int k = 0; k < 8; k++) begin
        enc(q[i][k], 1'b0);
      end
    end
    q.delete();
    b = 8'($random(seed));
    evs = '0;
    i_lftc_reader.sof();
    i_lftc_reader.byte_out(b);
    cap(h);
    chk(n > 1584 && n < 1664, 1);
    chk({evs.sof, evs.eof, evs.byte_v}, 3'h7);
    chk(gq.pop_back(), b);
  endtask : reply

  task automatic power_up();
    @(negedge clk_sys_i);
    i_lftc_reader.field_set(1'b1);
    wait_mode(M_SETTLE, 100);
    chk(mode_o, M_SETTLE);
    wait_mode(M_WIN, 3000);
    chk(n > 2480 && n < 2530, 1);
  endtask : power_up

  initial begin
    repeat (12) @(negedge clk_sys_i);
    chk({mode_o, mod_o, tx_ready_o, tx_busy_o}, 6'h02);
    rst_i = 1'b0;
    // Switch pattern, full FIFO held back, then a reply
    power_up();
    i_lftc_reader.swp();
    cyc_n(8);
    chk(mode_o, M_XCHG);
    fill(10);
    chk(q.size(), 8);
    chk(tx_ready_o, 0);
    repeat (300) begin
      cyc_n(1);
      chk(mod_o, 0);
    end
    reply(128);
    $display("test switch and reply done");
    // Lone stop condition, bad spacing, inventory reply
    evs = '0;
    i_lftc_reader.gap(6);
    i_lftc_reader.tc(60);
    chk(evs.slot, 1);
    evs = '0;
    i_lftc_reader.sof();
    i_lftc_reader.gap(24);
    i_lftc_reader.tc(250);
    chk({evs.sof, evs.err}, 2'h3);
    chk(mode_o, M_XCHG);
    inv_i = 1'b1;
    fill(1);
    reply(256);
    inv_i = 1'b0;
    $display("test slot, error, inventory done");
    // Short field drop keeps mode, long one resets it
    @(negedge clk_sys_i);
    i_lftc_reader.field_set(1'b0);
    cyc_n(100);
    i_lftc_reader.field_set(1'b1);
    cyc_n(10);
    chk(mode_o, M_XCHG);
    // Clock enable low freezes the field-off timer
    ce_i = 1'b0;
    i_lftc_reader.field_set(1'b0);
    cyc_n(300);
    chk(mode_o, M_XCHG);
    i_lftc_reader.field_set(1'b1);
    ce_i = 1'b1;
    cyc_n(10);
    chk(mode_o, M_XCHG);
    i_lftc_reader.field_set(1'b0);
    wait_mode(M_OFF, 400);
    chk(n > 195 && n < 215, 1);
    $display("test field drop done");
    // Silent window leads to broadcast, sent in four of the six rate and coding configurations
    power_up();
    wait_mode(M_BCAST, 2500);
    chk(n > 1840 && n < 1880, 1);
    foreach (cfgs[i]) begin
      cfg_i = cfgs[i];
      fill(1);
      lv = 1'b0;
      for (int k = 0; k < 8; k++) begin
        enc(q[0][k], cfgs[i][2]);
      end
      q.delete();
      cap(cfgs[i][1:0] == 2'h0 ? 256 : cfgs[i][1:0] == 2'h1 ? 128 : 64);
    end
    $display("test broadcast done");
    summarize();
  end
endmodule : tb
